// >>> src/vmtc_bank.sv
// Purpose: Trip point, filter and window configuration registers for monitor 8 to the HV monitor
// Assumes: Host engine presents byte accesses synchronous to clock, one strobe per access
//          No range limit on stored codes; the host keeps to the defined table
// Notes:   Decoded codes feed the analog comparators; table lookup happens in the analog domain
//          Illegal codes are stored as written; the legal flag only reports them
//          Decoded outputs lag the stored bytes by one edge

`timescale 1ns/1ns

// Overview of operation
// - Host writes trip, filter, window for monitors
// - Each monitor has independent trip A and B
// - Trip uses 6-bit fine and 4-bit coarse
// - No over/under voltage select control exists
// - Fine 0x21 disables hysteresis on input
// - Differential and single-ended use separate mappings
module vmtc_bank (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   resetn,
    // Register access from the host engine
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    output logic                        reg_rvalid,
    // Decoded configuration to the comparators
    output logic      [3:0]             mon8_trip_a_coarse_code,
    output logic      [3:0]             mon8_trip_b_coarse_code,
    output vmtc_pkg::vmtc_mon_cfg_t     mon9_cfg,
    output vmtc_pkg::vmtc_mon_cfg_t     hv_cfg
);

    // Register storage, one byte per offset
    logic [7:0] regs_q [vmtc_pkg::NUM_REGS];
    logic [7:0] regs_d [vmtc_pkg::NUM_REGS];
    // Read path
    logic [7:0] rdata_q, rdata_d;
    logic       rvalid_q, rvalid_d;
    // Decoded outputs held in flops
    logic [3:0]              m8a_q, m8a_d;
    logic [3:0]              m8b_q, m8b_d;
    vmtc_pkg::vmtc_mon_cfg_t m9_q, m9_d;
    vmtc_pkg::vmtc_mon_cfg_t hv_q, hv_d;
    // Offset relative to bank start, and hit flag
    // Below the bank the offset wraps; outside the bank it is never used
    logic [7:0] rel_addr;
    logic       hit;

    // Hit spans the first to the last offset of the bank, ends included
    assign rel_addr = reg_addr - vmtc_pkg::MON8_COARSE_OFS;
    assign hit      = (reg_addr >= vmtc_pkg::MON8_COARSE_OFS) &&
                      (reg_addr <= vmtc_pkg::HV_COARSE_OFS);

    // Legal code check; flags host mistakes, hardware still passes the code through
    // Refusing the write instead would leave a stale trip point in place
    function automatic logic code_legal(input logic [5:0] fine, input logic [3:0] coarse);
        code_legal = (coarse <= vmtc_pkg::COARSE_MAX) &&
                     ((fine <= vmtc_pkg::FINE_MAX) || (fine == vmtc_pkg::FINE_LOW_SENSE));
    endfunction

    // Build one comparator's selection
    // Legal and hysteresis flags ride along with the codes
    function automatic vmtc_pkg::vmtc_trip_t mk_trip(input logic [5:0] fine,
                                                     input logic [3:0] coarse);
        vmtc_pkg::vmtc_trip_t t;
        t.fine     = fine;
        t.coarse   = coarse;
        t.hyst_off = (fine == vmtc_pkg::FINE_LOW_SENSE);
        t.legal    = code_legal(fine, coarse);
        mk_trip    = t;
    endfunction

    // Decode a monitor's three registers
    // First holds fine B and two fine A bits, second filter, window and the rest
    // of fine A, third both coarse codes
    function automatic vmtc_pkg::vmtc_mon_cfg_t mk_cfg(input logic [7:0] r0,
                                                       input logic [7:0] r1,
                                                       input logic [7:0] r2,
                                                       input vmtc_pkg::vmtc_map_t map);
        vmtc_pkg::vmtc_mon_cfg_t c;
        logic [5:0]              fine_a;
        // Upper four bits from second register, lower two from first
        fine_a = {r1[vmtc_pkg::FINE_A_HI_MSB:vmtc_pkg::FINE_A_HI_LSB],
                  r0[vmtc_pkg::FINE_A_LO_MSB:vmtc_pkg::FINE_A_LO_LSB]};
        c.trip_a = mk_trip(fine_a,
                           r2[vmtc_pkg::COARSE_A_MSB:vmtc_pkg::COARSE_A_LSB]);
        c.trip_b = mk_trip(r0[vmtc_pkg::FINE_B_MSB:vmtc_pkg::FINE_B_LSB],
                           r2[vmtc_pkg::COARSE_B_MSB:vmtc_pkg::COARSE_B_LSB]);
        // Filter and window bits pass straight through
        c.glitch_filter_bypass  = r1[vmtc_pkg::FILT_BYP_BIT];
        c.window_compare_select = r1[vmtc_pkg::WINDOW_BIT];
        // One input, so either row in low-voltage sense removes its hysteresis
        c.hyst_off = c.trip_a.hyst_off | c.trip_b.hyst_off;
        // Direction is not stored; the same codes serve over and under use
        c.map_sel  = map;
        mk_cfg     = c;
    endfunction

    // Next register contents; writes outside the bank are dropped
    always_comb begin
        // Hold every byte by default
        for (int i = 0; i < vmtc_pkg::NUM_REGS; i++) begin
            regs_d[i] = regs_q[i];
        end
        // Only a strobe inside the bank changes storage; others are dropped silently
        if (reg_wr && hit) begin
            case (int'(rel_addr))
                // Filter and window bytes lose their two fixed bits
                vmtc_pkg::IDX_MON9_FILT,
                vmtc_pkg::IDX_HV_FILT: begin
                    // Top two bits are fixed ones, never stored
                    regs_d[int'(rel_addr)] = reg_wdata & vmtc_pkg::FILT_WR_MASK;
                end
                default: begin
                    // Whole byte kept, illegal codes included
                    regs_d[int'(rel_addr)] = reg_wdata;
                end
            endcase
        end
    end

    // Next read data; reads of unmapped offsets return zero
    always_comb begin
        // Data holds between reads; valid is a one-cycle pulse
        rvalid_d = reg_rd;
        rdata_d  = rdata_q;
        // Every read strobe is answered, mapped or not, so the host never waits
        if (reg_rd) begin
            // Fixed ones are merged on the way out, never stored
            if (hit) begin
                case (int'(rel_addr))
                    // Filter and window bytes show their fixed ones
                    vmtc_pkg::IDX_MON9_FILT,
                    vmtc_pkg::IDX_HV_FILT: begin
                        rdata_d = regs_q[int'(rel_addr)] | vmtc_pkg::FILT_FIXED_MASK;
                    end
                    default: begin
                        rdata_d = regs_q[int'(rel_addr)];
                    end
                endcase
            end else begin
                // Unmapped offset reads as zero
                rdata_d = vmtc_pkg::READ_UNMAPPED;
            end
        end
    end

    // Next decoded comparator settings, from the stored bytes
    always_comb begin
        // Monitor 8 has only its coarse byte in this bank
        m8a_d = regs_q[vmtc_pkg::IDX_MON8_COARSE][vmtc_pkg::COARSE_A_MSB:vmtc_pkg::COARSE_A_LSB];
        m8b_d = regs_q[vmtc_pkg::IDX_MON8_COARSE][vmtc_pkg::COARSE_B_MSB:vmtc_pkg::COARSE_B_LSB];
        // Monitor 9 uses the single-ended family
        m9_d  = mk_cfg(regs_q[vmtc_pkg::IDX_MON9_FINE], regs_q[vmtc_pkg::IDX_MON9_FILT],
                       regs_q[vmtc_pkg::IDX_MON9_COARSE], vmtc_pkg::VMTC_MAP_SINGLE);
        // High-voltage input keeps a table family of its own
        hv_d  = mk_cfg(regs_q[vmtc_pkg::IDX_HV_FINE], regs_q[vmtc_pkg::IDX_HV_FILT],
                       regs_q[vmtc_pkg::IDX_HV_COARSE], vmtc_pkg::VMTC_MAP_HIGH_V);
    end

    // Storage flops, one generate entry per register byte
    // A process per byte keeps each entry's single driver obvious
    for (genvar g = 0; g < vmtc_pkg::NUM_REGS; g++) begin : g_store
        // Async clear, then follow the write decode
        always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
                // Every stored bit starts at the same value
                regs_q[g] <= vmtc_pkg::REG_RESET;
            end else begin
                // Unchanged unless this entry was written
                regs_q[g] <= regs_d[g];
            end
        end
    end

    // Read path flops
    // Data holds between reads, so a slow sampler still sees the last answer
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            // No answer pending out of reset
            rdata_q  <= vmtc_pkg::REG_RESET;
            rvalid_q <= 1'b0;
        end else begin
            // Answer one edge after the strobe
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // Decoded output flops
    // Costs one edge of latency but keeps comparator inputs free of decode glitches
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            // All codes zero while held in reset; map family reads as zero too
            m8a_q <= 4'h0;
            m8b_q <= 4'h0;
            m9_q  <= '0;
            hv_q  <= '0;
        end else begin
            // Follow the stored bytes
            m8a_q <= m8a_d;
            m8b_q <= m8b_d;
            m9_q  <= m9_d;
            hv_q  <= hv_d;
        end
    end

    // Outputs straight from flops
    // No logic after the flops, so comparator inputs change only on a clock edge or at the async reset
    assign reg_rdata               = rdata_q;
    assign reg_rvalid              = rvalid_q;
    assign mon8_trip_a_coarse_code = m8a_q;
    assign mon8_trip_b_coarse_code = m8b_q;
    assign mon9_cfg                = m9_q;
    assign hv_cfg                  = hv_q;

endmodule // vmtc_bank

// >>> common/vmtc_pkg.sv
// Purpose: Shared constants and types for the voltage monitor trip configuration bank
// Assumes: Byte-wide register port driven by the serial host engine
// Notes:   Offsets are byte register addresses on the host link

package vmtc_pkg;

    // Register offsets
    localparam logic [7:0] MON8_COARSE_OFS = 8'h2D;   // monitor8_coarse_trip
    localparam logic [7:0] MON9_FINE_OFS   = 8'h2E;   // monitor9_fine_trip
    localparam logic [7:0] MON9_FILT_OFS   = 8'h2F;   // monitor9_filter_window_fine_hi
    localparam logic [7:0] MON9_COARSE_OFS = 8'h30;   // monitor9_coarse_trip
    localparam logic [7:0] HV_FINE_OFS     = 8'h31;   // high_voltage_fine_trip
    localparam logic [7:0] HV_FILT_OFS     = 8'h32;   // high_voltage_filter_window_fine_hi
    localparam logic [7:0] HV_COARSE_OFS   = 8'h33;   // high_voltage_coarse_trip
    localparam int         NUM_REGS        = 7;       // Bank depth, first at MON8_COARSE_OFS

    // Bank indices
    localparam int IDX_MON8_COARSE = 0;
    localparam int IDX_MON9_FINE   = 1;
    localparam int IDX_MON9_FILT   = 2;
    localparam int IDX_MON9_COARSE = 3;
    localparam int IDX_HV_FINE     = 4;
    localparam int IDX_HV_FILT     = 5;
    localparam int IDX_HV_COARSE   = 6;

    // Field positions, first configuration register
    localparam int FINE_A_LO_MSB = 7;
    localparam int FINE_A_LO_LSB = 6;
    localparam int FINE_B_MSB    = 5;
    localparam int FINE_B_LSB    = 0;
    // Field positions, second configuration register
    localparam int FILT_BYP_BIT  = 5;
    localparam int WINDOW_BIT    = 4;
    localparam int FINE_A_HI_MSB = 3;
    localparam int FINE_A_HI_LSB = 0;
    localparam logic [7:0] FILT_FIXED_MASK = 8'hC0;   // Bits 7:6 always read one
    localparam logic [7:0] FILT_WR_MASK    = 8'h3F;   // Writable part of that register
    // Field positions, third configuration register
    localparam int COARSE_A_MSB  = 7;
    localparam int COARSE_A_LSB  = 4;
    localparam int COARSE_B_MSB  = 3;
    localparam int COARSE_B_LSB  = 0;

    // Reset and code limits
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [5:0] FINE_MAX       = 6'h1E;    // Last normal fine row
    localparam logic [5:0] FINE_LOW_SENSE = 6'h21;    // Low-voltage sense row
    localparam logic [3:0] COARSE_MAX     = 4'hB;     // Last coarse column
    localparam logic [7:0] READ_UNMAPPED  = 8'h00;

    // Threshold mapping selection
    typedef enum logic [1:0] {
        VMTC_MAP_DIFF,        // Differential monitors 1 to 4
        VMTC_MAP_SINGLE,      // Single-ended monitors 5 to 9
        VMTC_MAP_HIGH_V       // High-voltage monitor
    } vmtc_map_t;

    // One comparator's trip selection
    typedef struct packed {
        logic [5:0] fine;     // Fine code
        logic [3:0] coarse;   // Coarse code
        logic       hyst_off; // Low-voltage sense, hysteresis removed
        logic       legal;    // Code inside the defined table
    } vmtc_trip_t;

    // One monitor's full decoded configuration
    typedef struct packed {
        vmtc_trip_t trip_a;               // Comparator A
        vmtc_trip_t trip_b;               // Comparator B
        logic       glitch_filter_bypass; // Filter bypass
        logic       window_compare_select;// Window mode
        logic       hyst_off;             // Either comparator in low-voltage sense
        vmtc_map_t  map_sel;              // Threshold table family
    } vmtc_mon_cfg_t;

endpackage

// >>> testbench/vmtc_bank_monitor.sv
// Purpose: Port-level assertions for the trip configuration bank
// Assumes: Byte strobe port; decoded outputs follow a write by two edges
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ns
module vmtc_bank_monitor (
    input wire logic                    clock,
    input wire logic                    resetn,
    input wire logic [7:0]              reg_addr,
    input wire logic [7:0]              reg_wdata,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [7:0]              reg_rdata,
    input wire logic                    reg_rvalid,
    input wire logic [3:0]              mon8_trip_a_coarse_code,
    input wire logic [3:0]              mon8_trip_b_coarse_code,
    input wire vmtc_pkg::vmtc_mon_cfg_t mon9_cfg,
    input wire vmtc_pkg::vmtc_mon_cfg_t hv_cfg
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    rvalid_pulse_a: assert property (reg_rvalid == $past(reg_rd))
        else $error("read answer not one edge after strobe");
    fixed_bits_a: assert property (
        reg_rd && reg_addr == 8'h2F |=> reg_rdata[7:6] == 2'b11)
        else $error("filter register top bits not one");
    mon8_coarse_a: assert property (
        reg_wr && reg_addr == 8'h2D |-> ##2
        {mon8_trip_a_coarse_code, mon8_trip_b_coarse_code} == $past(reg_wdata, 2))
        else $error("monitor 8 coarse codes wrong");
    fine_low_a: assert property (
        reg_wr && reg_addr == 8'h2E |-> ##2 mon9_cfg.trip_a.fine[1:0] == $past(reg_wdata[7:6], 2)
        && mon9_cfg.trip_b.fine == $past(reg_wdata[5:0], 2))
        else $error("monitor 9 fine codes wrong");
    fine_high_a: assert property (
        reg_wr && reg_addr == 8'h2F |-> ##2 {mon9_cfg.glitch_filter_bypass,
        mon9_cfg.window_compare_select, mon9_cfg.trip_a.fine[5:2]} == $past(reg_wdata[5:0], 2))
        else $error("monitor 9 filter, window or fine high wrong");
    hyst_off_a: assert property (
        mon9_cfg.trip_b.hyst_off == (mon9_cfg.trip_b.fine == 6'h21) && hv_cfg.hyst_off ==
        (hv_cfg.trip_a.fine == 6'h21 || hv_cfg.trip_b.fine == 6'h21))
        else $error("hysteresis removal not tied to low-sense code");
    map_split_a: assert property (
        $past(resetn) |-> mon9_cfg.map_sel == vmtc_pkg::VMTC_MAP_SINGLE
        && hv_cfg.map_sel == vmtc_pkg::VMTC_MAP_HIGH_V)
        else $error("threshold mapping family wrong");
    hv_coarse_a: assert property (
        reg_wr && reg_addr == 8'h33 |-> ##2
        {hv_cfg.trip_a.coarse, hv_cfg.trip_b.coarse} == $past(reg_wdata, 2))
        else $error("high-voltage coarse codes wrong");
    cover property (reg_wr && reg_addr == 8'h2E);
    cover property (reg_rvalid && reg_rdata[7:6] == 2'b11);
    cover property (mon9_cfg.hyst_off && hv_cfg.hyst_off);
endmodule // vmtc_bank_monitor
bind vmtc_bank vmtc_bank_monitor mon_i (.clock(clock), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .mon8_trip_a_coarse_code(mon8_trip_a_coarse_code),
    .mon8_trip_b_coarse_code(mon8_trip_b_coarse_code), .mon9_cfg(mon9_cfg), .hv_cfg(hv_cfg));

// >>> testbench/vmtc_host.sv
// Purpose: Host model issuing byte register strobes
// Assumes: Strobes change at the falling edge, taken at the next rising edge
// Notes:   Released address and data lines show the inverse of the last value
`timescale 1ns/1ns
module vmtc_host (
    input  wire logic       clock,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    // Idle bus from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Callers only pass codes inside the defined table
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // Answer is taken half a cycle after the edge that raised it
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
        v = reg_rvalid;
    endtask
endmodule // vmtc_host

// >>> testbench/voltage_monitor_trip_config_tb.sv
// Purpose: Self-checking bench for the trip configuration bank
// Assumes: Host model drives every register access
// Notes:   Decoded outputs are checked two edges after the last write
`timescale 1ns/1ns
module voltage_monitor_trip_config_tb;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_d;
    logic clock, resetn, reg_wr, reg_rd, reg_rvalid, rd_v;
    logic [3:0] c8a, c8b;
    vmtc_pkg::vmtc_mon_cfg_t m9, hv;
    int n_fail = 0;
    int compares = 0;
    vmtc_bank uut (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .mon8_trip_a_coarse_code(c8a), .mon8_trip_b_coarse_code(c8b), .mon9_cfg(m9), .hv_cfg(hv));
    vmtc_host host (.clock(clock), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Read with answer flag and data both judged
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rd_d, rd_v);
        cmp({7'h00, rd_v}, 8'h01);
        cmp(rd_d, e);
    endtask
    task automatic t_reset;
        rchk(8'h2D, 8'h00);
        rchk(8'h2F, 8'hC0);
        cmp({6'h00, m9.map_sel}, {6'h00, vmtc_pkg::VMTC_MAP_SINGLE});
        cmp({6'h00, hv.map_sel}, {6'h00, vmtc_pkg::VMTC_MAP_HIGH_V});
    endtask
    // Top bits written as one too; they must read one anyway
    task automatic t_mon9;
        host.wr(8'h2E, 8'hA1);
        host.wr(8'h2F, 8'hF7);
        repeat (2) @(negedge clock);
        cmp({2'b00, m9.trip_a.fine}, 8'h1E);
        cmp({2'b00, m9.trip_b.fine}, 8'h21);
        cmp({6'h00, m9.trip_b.hyst_off, m9.trip_a.hyst_off}, 8'h02);
        cmp({7'h00, m9.hyst_off}, 8'h01);
        cmp({6'h00, m9.glitch_filter_bypass, m9.window_compare_select}, 8'h03);
        rchk(8'h2F, 8'hF7);
    endtask
    task automatic t_coarse;
        host.wr(8'h2D, 8'h0B);
        host.wr(8'h30, 8'hB5);
        host.wr(8'h33, 8'hA3);
        repeat (2) @(negedge clock);
        cmp({c8a, c8b}, 8'h0B);
        cmp({m9.trip_a.coarse, m9.trip_b.coarse}, 8'hB5);
        cmp({hv.trip_a.coarse, hv.trip_b.coarse}, 8'hA3);
        cmp({6'h00, m9.trip_a.legal, m9.trip_b.legal}, 8'h03);
    endtask
    // Low-sense on the high-voltage A side must leave monitor 9 alone
    task automatic t_hv;
        host.wr(8'h31, 8'h40);
        host.wr(8'h32, 8'h18);
        repeat (2) @(negedge clock);
        cmp({2'b00, hv.trip_a.fine}, 8'h21);
        cmp({7'h00, hv.hyst_off}, 8'h01);
        cmp({6'h00, hv.glitch_filter_bypass, hv.window_compare_select}, 8'h01);
        cmp({2'b00, m9.trip_b.fine}, 8'h21);
    endtask
    task automatic t_unmapped;
        host.wr(8'h34, 8'hFF);
        rchk(8'h34, 8'h00);
        rchk(8'h33, 8'hA3);
    endtask
    task automatic end_sim;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        resetn = 1'b0;
        repeat (10) @(negedge clock);
        resetn = 1'b1;
        t_reset();
        t_mon9();
        t_coarse();
        t_hv();
        t_unmapped();
        end_sim();
    end
    // Whole run needs about forty cycles
    initial begin
        #80000;
        n_fail++;
        end_sim();
    end
endmodule // voltage_monitor_trip_config_tb
